// ### core/crt_timer.sv
// 16-bit capture / auto-reload / baud-rate timer with register port
//
// Contract
// - trigger fall in capture copies counter
// - clear count source: system_clock/1 or /12 else pin
// - rollover outside baud mode sets overflow flag and interrupt
// - capture needs select and run; trigger enable
// - reload mode overflow loads capture registers
// - enabled trigger fall reloads in reload mode
// - trigger capture/reload sets external edge flag
// - flags cleared only by software write
// - baud selects force reload, ignore capture select
// - baud overflow reloads, no flag, pulses uart
// - rx and tx baud selects chosen independently
// - uart divides overflow pulses by sixteen
// - baud mode internal tick is system_clock/2
// - pin-clocked baud: pin freq over 16(65536-reload)
// - baud mode trigger fall sets edge flag
// - run clear holds count, set enables
// - capture registers hold reload outside capture
// - divide select: 0 is /12, 1 undivided
`timescale 1ns/1ps
`default_nettype none
module crt_timer #(
  parameter int DIV_SLOW = crt_pkg::CRT_DIV_SLOW,
  parameter int DIV_BAUD = crt_pkg::CRT_DIV_BAUD
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // special function register port
  input wire crt_pkg::crt_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // external pins
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  // interrupt request and uart shift clock pulses
  output logic timer_irq,
  output var crt_pkg::crt_baud_t baud_tick
);
  import crt_pkg::*;

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  localparam int PW = $clog2(DIV_SLOW > 1 ? DIV_SLOW : 2);
  if (DIV_SLOW < 2 || DIV_BAUD < 2 || DIV_BAUD > DIV_SLOW) begin : g_chk
    $error("crt_timer: prescale divisors out of range");
  end
  localparam logic [PW-1:0] PRE_SLOW_LAST = PW'(DIV_SLOW - 1);
  localparam logic [PW-1:0] PRE_BAUD_LAST = PW'(DIV_BAUD - 1);
  localparam logic [PW-1:0] PRE_ZERO = '0;
  localparam logic [PW-1:0] PRE_ONE = PW'(1);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic count_fall;
  logic trig_fall;

  crt_edge_sync u_count_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(count_input_pin),
    .fall(count_fall)
  );

  crt_edge_sync u_trig_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(trigger_pin),
    .fall(trig_fall)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0] timer_control;
  logic [7:0] capture_reload_low;
  logic [7:0] capture_reload_high;
  logic [15:0] count;
  logic clock_divide_select;
  logic [PW-1:0] pre;
  logic [7:0] next_timer_control;
  logic [7:0] next_capture_reload_low;
  logic [7:0] next_capture_reload_high;
  logic [15:0] next_count;
  logic next_clock_divide_select;
  logic [PW-1:0] next_pre;
  logic [7:0] next_rdata;
  logic next_irq;
  crt_baud_t next_baud;

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  logic overflow_flag;
  logic external_edge_flag;
  logic rx_baud_select;
  logic tx_baud_select;
  logic external_trigger_enable;
  logic run_control;
  logic count_source_select;
  logic capture_reload_select;
  crt_mode_t mode;

  assign overflow_flag = timer_control[CRT_BIT_OVF];
  assign external_edge_flag = timer_control[CRT_BIT_EXF];
  assign rx_baud_select = timer_control[CRT_BIT_RXB];
  assign tx_baud_select = timer_control[CRT_BIT_TXB];
  assign external_trigger_enable = timer_control[CRT_BIT_EXEN];
  assign run_control = timer_control[CRT_BIT_RUN];
  assign count_source_select = timer_control[CRT_BIT_CSRC];
  assign capture_reload_select = timer_control[CRT_BIT_CAPSEL];

  always_comb begin
    if (!run_control) begin
      mode = CRT_MODE_OFF;
    end else if (rx_baud_select || tx_baud_select) begin
      mode = CRT_MODE_BAUD;
    end else if (capture_reload_select) begin
      mode = CRT_MODE_CAPTURE;
    end else begin
      mode = CRT_MODE_RELOAD;
    end
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  logic tick;
  logic trig_hit;
  logic roll;
  logic set_ovf;
  logic set_exf;
  logic reload;
  logic sw_ctrl;
  logic [PW-1:0] pre_last;

  always_comb begin
    next_timer_control = timer_control;
    next_capture_reload_low = capture_reload_low;
    next_capture_reload_high = capture_reload_high;
    next_count = count;
    next_clock_divide_select = clock_divide_select;
    next_pre = pre;
    next_baud = '0;
    tick = 1'b0;
    set_ovf = 1'b0;
    set_exf = 1'b0;
    reload = 1'b0;
    sw_ctrl = sfr_req.wr && (sfr_req.addr == CRT_ADDR_CTRL);
    // baud mode fixes /2; divide select only matters as a timer
    if (mode == CRT_MODE_BAUD) begin
      pre_last = PRE_BAUD_LAST;
    end else begin
      pre_last = PRE_SLOW_LAST;
    end
    // prescaler keeps running so the tick grid stays regular
    if (pre >= pre_last) begin
      next_pre = PRE_ZERO;
    end else begin
      next_pre = pre + PRE_ONE;
    end
    case (mode)
      CRT_MODE_OFF: begin
        tick = 1'b0;
      end
      CRT_MODE_BAUD: begin
        // pin-clocked rate is pin frequency over 16 times the span
        tick = count_source_select ? count_fall : (pre >= pre_last);
      end
      CRT_MODE_CAPTURE, CRT_MODE_RELOAD: begin
        if (count_source_select) begin
          tick = count_fall;
        end else if (clock_divide_select) begin
          tick = 1'b1;
        end else begin
          tick = (pre >= pre_last);
        end
      end
      default: begin
        tick = 1'b0;
      end
    endcase
    roll = tick && (count == CRT_CNT_MAX);
    trig_hit = trig_fall && external_trigger_enable &&
               (mode != CRT_MODE_OFF);
    // count path
    if (tick) begin
      next_count = count + CRT_CNT_ONE;
    end
    case (mode)
      CRT_MODE_CAPTURE: begin
        if (roll) begin
          set_ovf = 1'b1;
        end
        if (trig_hit) begin
          next_capture_reload_high = next_count[15:8];
          next_capture_reload_low = next_count[7:0];
          set_exf = 1'b1;
        end
      end
      CRT_MODE_RELOAD: begin
        if (roll) begin
          set_ovf = 1'b1;
          reload = 1'b1;
        end
        if (trig_hit) begin
          reload = 1'b1;
          set_exf = 1'b1;
        end
      end
      CRT_MODE_BAUD: begin
        if (roll) begin
          reload = 1'b1;
          next_baud.rx_tick = rx_baud_select;
          next_baud.tx_tick = tx_baud_select;
        end
        if (trig_hit) begin
          set_exf = 1'b1;
        end
      end
      default: begin
        reload = 1'b0;
      end
    endcase
    // software writes to the byte registers
    if (sfr_req.wr) begin
      case (sfr_req.addr)
        CRT_ADDR_CAPL: begin
          next_capture_reload_low = sfr_req.wdata;
        end
        CRT_ADDR_CAPH: begin
          next_capture_reload_high = sfr_req.wdata;
        end
        CRT_ADDR_CNTL: begin
          next_count[7:0] = sfr_req.wdata;
        end
        CRT_ADDR_CNTH: begin
          next_count[15:8] = sfr_req.wdata;
        end
        CRT_ADDR_CKDIV: begin
          next_clock_divide_select = sfr_req.wdata[CRT_BIT_CKDIV];
        end
        default: begin
          next_clock_divide_select = clock_divide_select;
        end
      endcase
    end
    // reload uses the held value (a same-cycle software write loses)
    if (reload) begin
      next_count = {capture_reload_high, capture_reload_low};
    end
    if (sw_ctrl) begin
      next_timer_control = sfr_req.wdata;
    end
    // hardware set wins over a software clear in the same cycle
    if (set_ovf) begin
      next_timer_control[CRT_BIT_OVF] = 1'b1;
    end
    if (set_exf) begin
      next_timer_control[CRT_BIT_EXF] = 1'b1;
    end
    next_irq = next_timer_control[CRT_BIT_OVF] |
               next_timer_control[CRT_BIT_EXF];
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        CRT_ADDR_CTRL: next_rdata = timer_control;
        CRT_ADDR_CAPL: next_rdata = capture_reload_low;
        CRT_ADDR_CAPH: next_rdata = capture_reload_high;
        CRT_ADDR_CNTL: next_rdata = count[7:0];
        CRT_ADDR_CNTH: next_rdata = count[15:8];
        CRT_ADDR_CKDIV: begin
          next_rdata = CRT_RST_BYTE;
          next_rdata[CRT_BIT_CKDIV] = clock_divide_select;
        end
        default: next_rdata = CRT_RST_BYTE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      timer_control <= CRT_RST_BYTE;
      capture_reload_low <= CRT_RST_BYTE;
      capture_reload_high <= CRT_RST_BYTE;
      count <= '0;
      clock_divide_select <= 1'b0;
      pre <= PRE_ZERO;
      sfr_rdata <= CRT_RST_BYTE;
      timer_irq <= 1'b0;
      baud_tick <= '0;
    end else begin
      timer_control <= next_timer_control;
      capture_reload_low <= next_capture_reload_low;
      capture_reload_high <= next_capture_reload_high;
      count <= next_count;
      clock_divide_select <= next_clock_divide_select;
      pre <= next_pre;
      sfr_rdata <= next_rdata;
      timer_irq <= next_irq;
      baud_tick <= next_baud;
    end
  end
endmodule // crt_timer
`default_nettype wire

// ### core/crt_pkg.sv
// constants and carrier types for the capture/reload timer
package crt_pkg;
  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] CRT_ADDR_CTRL = 8'hc8;
  localparam logic [7:0] CRT_ADDR_CAPL = 8'hca;
  localparam logic [7:0] CRT_ADDR_CAPH = 8'hcb;
  localparam logic [7:0] CRT_ADDR_CNTL = 8'hcc;
  localparam logic [7:0] CRT_ADDR_CNTH = 8'hcd;
  localparam logic [7:0] CRT_ADDR_CKDIV = 8'h8e;
  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CRT_BIT_OVF = 7;
  localparam int CRT_BIT_EXF = 6;
  localparam int CRT_BIT_RXB = 5;
  localparam int CRT_BIT_TXB = 4;
  localparam int CRT_BIT_EXEN = 3;
  localparam int CRT_BIT_RUN = 2;
  localparam int CRT_BIT_CSRC = 1;
  localparam int CRT_BIT_CAPSEL = 0;
  localparam int CRT_BIT_CKDIV = 5;
  localparam logic [7:0] CRT_RST_BYTE = 8'h00;
  localparam logic [15:0] CRT_CNT_MAX = 16'hffff;
  localparam logic [15:0] CRT_CNT_ONE = 16'h0001;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CRT_DIV_SLOW = 12;
  localparam int CRT_DIV_BAUD = 2;
  localparam int CRT_UART_DIV = 16;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CRT_MODE_OFF = 2'b00,
    CRT_MODE_CAPTURE = 2'b01,
    CRT_MODE_RELOAD = 2'b10,
    CRT_MODE_BAUD = 2'b11
  } crt_mode_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crt_sfr_req_t;
  typedef struct packed {
    logic rx_tick;
    logic tx_tick;
  } crt_baud_t;
endpackage

// ### core/crt_edge_sync.sv
// two-stage synchroniser with falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module crt_edge_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pin and event
  input wire logic pin,
  output logic fall
);
  logic meta;
  logic sync;
  logic last;
  logic next_fall;

  // meta feeds only sync; edge compares sync with last
  always_comb begin
    next_fall = last & ~sync;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
      fall <= 1'b0;
    end else begin
      meta <= pin;
      sync <= meta;
      last <= sync;
      fall <= next_fall;
    end
  end
endmodule // crt_edge_sync
`default_nettype wire

// ### sim/crt_timer_props.sv
// assertion checker for the capture/reload timer ports
`timescale 1ns/1ps
`default_nettype none
module crt_timer_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // register port
  input wire crt_pkg::crt_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // pins and outputs
  input wire logic count_input_pin,
  input wire logic trigger_pin,
  input wire logic timer_irq,
  input wire crt_pkg::crt_baud_t baud_tick
);
  import crt_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_rd_hold: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_req.rd && sfr_req.addr == 8'hc9
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_reload_readback: assert property (
    sfr_req.wr && sfr_req.addr == CRT_ADDR_CAPH ##2 sfr_req.rd &&
    sfr_req.addr == CRT_ADDR_CAPH |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("reload high readback wrong");
  a_div_readback: assert property (
    sfr_req.wr && sfr_req.addr == CRT_ADDR_CKDIV ##2 sfr_req.rd &&
    sfr_req.addr == CRT_ADDR_CKDIV |=> sfr_rdata[7:5] ==
    {2'b00, $past(sfr_req.wdata[5], 3)}) else $error("divider readback");
  a_ctrl_idle_rb: assert property (
    sfr_req.wr && sfr_req.addr == CRT_ADDR_CTRL &&
    sfr_req.wdata[7:6] == 2'b00 && !sfr_req.wdata[2] ##2 sfr_req.rd &&
    sfr_req.addr == CRT_ADDR_CTRL |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("stopped control readback wrong");
  a_rx_pulse: assert property (
    baud_tick.rx_tick |=> !baud_tick.rx_tick)
    else $error("receive tick longer than one cycle");
  a_tx_pulse: assert property (
    baud_tick.tx_tick |=> !baud_tick.tx_tick)
    else $error("transmit tick longer than one cycle");
  // the request register follows the control write at the same edge
  a_flag_sticky: assert property ($fell(timer_irq) |->
    $past(sfr_req.wr && sfr_req.addr == CRT_ADDR_CTRL, 1))
    else $error("request dropped without software clear");
  c_rx: cover property (baud_tick.rx_tick);
  c_tx: cover property (baud_tick.tx_tick);
  c_irq: cover property ($rose(timer_irq));
endmodule // crt_timer_props
bind crt_timer crt_timer_props u_crt_timer_props (.clk_sys(clk_sys),
  .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .count_input_pin(count_input_pin), .trigger_pin(trigger_pin),
  .timer_irq(timer_irq), .baud_tick(baud_tick));
`default_nettype wire

// ### sim/crt_pin_model.sv
// pin drivers and uart bit counter facing the timer
`timescale 1ns/1ps
`default_nettype none
module crt_pin_model (
  // clock
  input wire logic clk_sys,
  // pins toward the timer
  output logic count_input_pin,
  output logic trigger_pin,
  // uart side
  input wire crt_pkg::crt_baud_t baud_tick,
  output int rx_bits,
  output int tx_bits
);
  import crt_pkg::*;
  int rx_n;
  int tx_n;
  initial begin
    count_input_pin = 1'b1;
    trigger_pin = 1'b1;
    rx_n = 0;
    tx_n = 0;
  end
  always @(posedge clk_sys) begin
    if (baud_tick.rx_tick) rx_n <= rx_n + 1;
    if (baud_tick.tx_tick) tx_n <= tx_n + 1;
  end
  // shift logic takes sixteen ticks per bit
  assign rx_bits = rx_n / CRT_UART_DIV;
  assign tx_bits = tx_n / CRT_UART_DIV;
  // low and high kept past the two-clock minimum so no edge is lost
  task automatic pulse(input logic trig, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (trig) trigger_pin <= 1'b0;
      else count_input_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      trigger_pin <= 1'b1;
      count_input_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule // crt_pin_model
`default_nettype wire

// ### sim/crt_timer_bench.sv
// self-checking bench for the capture/reload timer
`timescale 1ns/1ps
`default_nettype none
module crt_timer_bench;
  import crt_pkg::*;
  logic clk_sys, nrst, timer_irq;
  crt_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata, rv;
  crt_baud_t baud_tick;
  wire logic cnt_pin, trg_pin;
  int rx_bits, tx_bits, n_mismatch, n_compared, r0, t0;
  crt_timer #(.DIV_SLOW(12), .DIV_BAUD(2)) u_crt_timer (.clk_sys(clk_sys),
    .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .count_input_pin(cnt_pin), .trigger_pin(trg_pin),
    .timer_irq(timer_irq), .baud_tick(baud_tick));
  crt_pin_model u_crt_pin_model (.clk_sys(clk_sys), .count_input_pin(cnt_pin),
    .trigger_pin(trg_pin), .baud_tick(baud_tick), .rx_bits(rx_bits),
    .tx_bits(tx_bits));
  function automatic int bits_exp(input int clks, input logic [15:0] rl);
    return clks / (CRT_DIV_BAUD * (32'h10000 - rl)) / CRT_UART_DIV;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    sfr_req.wr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    sfr_req.rd <= 1'b0;
    @(negedge clk_sys);
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // far above the roughly 4600 cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    sfr_req = '0;
    rv = 8'($urandom(75) % 240);
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(CRT_ADDR_CTRL, 8'h00);
    rdc(CRT_ADDR_CAPL, 8'h00);
    rdc(CRT_ADDR_CAPH, 8'h00);
    rdc(CRT_ADDR_CNTL, 8'h00);
    rdc(8'hc9, 8'h00);
    wr(CRT_ADDR_CKDIV, 8'h20);
    rdc(CRT_ADDR_CKDIV, 8'h20);
    // capture mode clocked from the count pin, crossing the rollover
    wr(CRT_ADDR_CNTL, 8'hfe);
    wr(CRT_ADDR_CNTH, 8'hff);
    wr(CRT_ADDR_CTRL, 8'h0b);
    u_crt_pin_model.pulse(1'b0, 2);
    rdc(CRT_ADDR_CNTL, 8'hfe);
    wr(CRT_ADDR_CTRL, 8'h0f);
    u_crt_pin_model.pulse(1'b0, 5);
    u_crt_pin_model.pulse(1'b1, 1);
    rdc(CRT_ADDR_CTRL, 8'hcf);
    rdc(CRT_ADDR_CAPL, 8'h03);
    rdc(CRT_ADDR_CAPH, 8'h00);
    check(16'(timer_irq), 16'h0001);
    wr(CRT_ADDR_CTRL, 8'h0f);
    repeat (3) @(posedge clk_sys);
    check(16'(timer_irq), 16'h0000);
    // auto-reload on overflow and on trigger edge
    wr(CRT_ADDR_CAPL, rv);
    wr(CRT_ADDR_CAPH, 8'hff);
    wr(CRT_ADDR_CNTL, 8'hff);
    wr(CRT_ADDR_CNTH, 8'hff);
    wr(CRT_ADDR_CTRL, 8'h0e);
    u_crt_pin_model.pulse(1'b0, 1);
    rdc(CRT_ADDR_CNTL, rv);
    rdc(CRT_ADDR_CTRL, 8'h8e);
    u_crt_pin_model.pulse(1'b0, 2);
    u_crt_pin_model.pulse(1'b1, 1);
    rdc(CRT_ADDR_CNTL, rv);
    rdc(CRT_ADDR_CTRL, 8'hce);
    wr(CRT_ADDR_CTRL, 8'h06);
    u_crt_pin_model.pulse(1'b0, 1);
    u_crt_pin_model.pulse(1'b1, 1);
    rdc(CRT_ADDR_CNTL, rv + 8'h01);
    rdc(CRT_ADDR_CTRL, 8'h06);
    // baud generation, capture select set but ignored
    wr(CRT_ADDR_CAPL, 8'hf0);
    wr(CRT_ADDR_CNTL, 8'hf0);
    wr(CRT_ADDR_CTRL, 8'h3d);
    repeat (2064) @(posedge clk_sys);
    check(16'(rx_bits), 16'(bits_exp(2064, 16'hfff0)));
    check(16'(tx_bits), 16'(bits_exp(2064, 16'hfff0)));
    rdc(CRT_ADDR_CTRL, 8'h3d);
    u_crt_pin_model.pulse(1'b1, 1);
    rdc(CRT_ADDR_CTRL, 8'h7d);
    wr(CRT_ADDR_CTRL, 8'h24);
    r0 = rx_bits;
    t0 = tx_bits;
    repeat (2048) @(posedge clk_sys);
    check(16'(rx_bits - r0), 16'(bits_exp(2048, 16'hfff0)));
    check(16'(tx_bits - t0), 16'h0000);
    // undivided system clock: ticks on every edge while running
    wr(CRT_ADDR_CTRL, 8'h00);
    wr(CRT_ADDR_CNTL, 8'h00);
    wr(CRT_ADDR_CNTH, 8'h00);
    wr(CRT_ADDR_CTRL, 8'h04);
    repeat (20) @(posedge clk_sys);
    wr(CRT_ADDR_CTRL, 8'h00);
    rdc(CRT_ADDR_CNTL, 8'h16);
    // divide by twelve: a run window of 240 edges gives 20 ticks
    wr(CRT_ADDR_CKDIV, 8'h00);
    wr(CRT_ADDR_CNTL, 8'h00);
    wr(CRT_ADDR_CTRL, 8'h04);
    repeat (238) @(posedge clk_sys);
    wr(CRT_ADDR_CTRL, 8'h00);
    rdc(CRT_ADDR_CNTL, 8'h14);
    stop_test();
  end
endmodule // crt_timer_bench
`default_nettype wire
